// *** hdl/vec_pkg.sv ***
/*
 vacuum ejector controller: shared constants, reset values and mode type.
 assumes a 100 MHz system clock; vacuum values are sensor counts.
*/
package vec_pkg;
   // clock and time bases
   localparam int VEC_CLK_NS = 10;
   localparam int VEC_DEB_MS = 10;
   localparam int VEC_TICK_MS = 10;
   localparam int VEC_HOLD_S = 3;
   localparam int VEC_FLASH_MS = 250;
   localparam int VEC_DEB_CYC = VEC_DEB_MS * 1000000 / VEC_CLK_NS;
   localparam int VEC_TICK_CYC = VEC_TICK_MS * 1000000 / VEC_CLK_NS;
   localparam int VEC_HOLD_CYC = VEC_HOLD_S * 1000000000 / VEC_CLK_NS;
   localparam int VEC_FLASH_CYC = VEC_FLASH_MS * 1000000 / VEC_CLK_NS;
   // data widths
   localparam int VEC_VAC_W = 12;
   localparam int VEC_LIM_W = 10;
   localparam int VEC_BLOW_W = 10;
   // blow-off time in hundredths of a second, 0 selects external mode
   localparam logic [VEC_BLOW_W-1:0] VEC_BLOW_MAX = 10'h3e7;
   // zero calibration window: 3 percent of full scale
   localparam int VEC_FULL_SCALE = 1000;
   localparam int VEC_CAL_PCT = 3;
   localparam int VEC_CAL_LIM = VEC_FULL_SCALE * VEC_CAL_PCT / 100;
   // reset values of the configuration
   localparam logic [VEC_LIM_W-1:0] VEC_RST_SAVE_UP = 10'h258;
   localparam logic [VEC_LIM_W-1:0] VEC_RST_SAVE_LO = 10'h1f4;
   localparam logic [VEC_LIM_W-1:0] VEC_RST_PART_ON = 10'h190;
   localparam logic [VEC_LIM_W-1:0] VEC_RST_PART_OFF = 10'h15e;
   localparam logic [VEC_BLOW_W-1:0] VEC_RST_BLOW = 10'h000;
   localparam logic VEC_RST_CTRL = 1'b1;
   // debounced input bit positions
   localparam int VEC_IN_SUC = 0;
   localparam int VEC_IN_BLOW = 1;
   localparam int VEC_IN_MENU = 2;
   localparam int VEC_IN_PLUS = 3;
   localparam int VEC_IN_N = 4;

   typedef enum logic {VEC_AUTO, VEC_MANUAL} vec_mode_t;
endpackage : vec_pkg

// *** hdl/vec_debounce.sv ***
/*
 two-flop synchroniser and stability debouncer, one lane per input bit.
 assumes raw inputs are asynchronous pins; outputs are clean levels.
*/
`timescale 1ns/1ns
`default_nettype none
module vec_debounce #(
   parameter int N = 4,
   parameter int DB_CYCLES = 1000000
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [N-1:0] raw,
   output logic [N-1:0] clean
);
   localparam int CW = $clog2(DB_CYCLES + 1);

   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_lane
         logic s1, s2, lvl, next_lvl;
         logic [CW-1:0] cnt, next_cnt;
         // accept a new level only after it stood for DB_CYCLES
         always_comb
         begin
            next_lvl = lvl;
            next_cnt = '0;
            if (s2 != lvl)
            begin
               if (cnt == CW'(DB_CYCLES - 1))
                  next_lvl = s2;
               else
                  next_cnt = cnt + 1'b1;
            end
         end
         always_ff @(posedge clk_sys or posedge sys_rst)
         begin
            if (sys_rst)
            begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               lvl <= 1'b0;
               cnt <= '0;
            end
            else
            begin
               s1 <= raw[i];
               s2 <= s1;
               lvl <= next_lvl;
               cnt <= next_cnt;
            end
         end
         assign clean[i] = lvl;
      end
   endgenerate
endmodule : vec_debounce
`default_nettype wire

// *** hdl/vec_blow_timer.sv ***
/*
 blow-off duration timer counting down in 10 ms ticks.
 assumes start is a one-cycle pulse on the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module vec_blow_timer #(
   parameter int W = 10,
   parameter int TICK_CYCLES = 1000000
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic [W-1:0] load,
   output logic active
);
   logic [31:0] presc, next_presc;
   logic [W-1:0] remain, next_remain;

   // restart on start, else step down once per tick
   always_comb
   begin
      next_presc = presc;
      next_remain = remain;
      if (start)
      begin
         next_presc = '0;
         next_remain = load;
      end
      else if (remain != '0)
      begin
         if (presc == 32'(TICK_CYCLES - 1))
         begin
            next_presc = '0;
            next_remain = remain - 1'b1;
         end
         else
            next_presc = presc + 32'h1;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         presc <= '0;
         remain <= '0;
         active <= 1'b0;
      end
      else
      begin
         presc <= next_presc;
         remain <= next_remain;
         active <= (next_remain != '0);
      end
   end
endmodule : vec_blow_timer
`default_nettype wire

// *** hdl/vec_ctrl.sv ***
/*
 vacuum ejector control core: valves, air saving, part present,
 blow-off modes, manual mode, zero calibration and parameter intake.
 assumes pins for commands and buttons, vacuum samples and config
 on the system clock, and one power-on reset.
*/
`timescale 1ns/1ns
`default_nettype none
module vec_ctrl
   import vec_pkg::*;
#(
   parameter int DEB_CYCLES = VEC_DEB_CYC,
   parameter int TICK_CYCLES = VEC_TICK_CYC,
   parameter int HOLD_CYCLES = VEC_HOLD_CYC,
   parameter int FLASH_CYCLES = VEC_FLASH_CYC
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic cmd_suction,
   input wire logic cmd_blowoff,
   input wire logic btn_menu,
   input wire logic btn_plus,
   input wire logic signed [VEC_VAC_W-1:0] vacuum_raw,
   input wire logic nc_variant,
   input wire logic cfg_load,
   input wire logic cfg_ctrl_enable,
   input wire logic [VEC_LIM_W-1:0] cfg_save_upper_limit,
   input wire logic [VEC_LIM_W-1:0] cfg_save_lower_limit,
   input wire logic [VEC_LIM_W-1:0] cfg_part_on_limit,
   input wire logic [VEC_LIM_W-1:0] cfg_part_off_limit,
   input wire logic [VEC_BLOW_W-1:0] cfg_blow_time,
   input wire logic cal_request,
   output logic nozzle_drive,
   output logic suction_valve,
   output logic blowoff_valve,
   output logic blowoff_indication,
   output logic part_present,
   output logic led_limit1,
   output logic led_limit2,
   output logic led_suction,
   output logic led_blowoff,
   output logic manual_mode,
   output logic cfg_rejected,
   output logic cal_error
);
   logic [VEC_IN_N-1:0] inp, inp_prev;
   vec_mode_t mode, next_mode;
   logic [31:0] hold_cnt, next_hold_cnt, flash_cnt, next_flash_cnt;
   logic wait_rel, next_wait_rel, man_suck, next_man_suck, flash, next_flash;
   logic ctrl_en, next_ctrl_en, rejected, next_rejected;
   logic [VEC_LIM_W-1:0] save_up, next_save_up, save_lo, next_save_lo;
   logic [VEC_LIM_W-1:0] part_on, next_part_on, part_off, next_part_off;
   logic [VEC_BLOW_W-1:0] blow_time, next_blow_time;
   logic signed [VEC_VAC_W-1:0] offset, next_offset;
   logic cal_err, next_cal_err;
   logic signed [VEC_VAC_W:0] diff;
   logic [VEC_VAC_W-1:0] vac;
   logic combo, combo_prev, menu_rise, cmd_chg;
   logic suck_req, blow_req, suck_prev, suck_fall, tmr_active;
   logic blow, suction_on, save_off, next_save_off, gen, part, next_part;

   // clean, synchronised commands and buttons
   vec_debounce #(
      .N(VEC_IN_N),
      .DB_CYCLES(DEB_CYCLES)
   ) u_deb (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .raw({btn_plus, btn_menu, cmd_blowoff, cmd_suction}),
      .clean(inp)
   );

   // button and command edge terms
   assign combo = inp[VEC_IN_MENU] & inp[VEC_IN_PLUS];
   assign combo_prev = inp_prev[VEC_IN_MENU] & inp_prev[VEC_IN_PLUS];
   assign menu_rise = inp[VEC_IN_MENU] & ~inp_prev[VEC_IN_MENU];
   assign cmd_chg = (inp[VEC_IN_SUC] != inp_prev[VEC_IN_SUC])
                  | (inp[VEC_IN_BLOW] != inp_prev[VEC_IN_BLOW]);

   // operating mode, manual suction toggle and led flashing
   always_comb
   begin
      next_mode = mode;
      next_hold_cnt = '0;
      next_wait_rel = wait_rel;
      next_man_suck = man_suck;
      next_flash_cnt = '0;
      next_flash = 1'b0;
      unique case (mode)
         VEC_AUTO:
         begin
            next_man_suck = 1'b0;
            next_wait_rel = 1'b0;
            if (combo)
            begin
               if (hold_cnt == 32'(HOLD_CYCLES - 1))
               begin
                  next_mode = VEC_MANUAL;
                  next_wait_rel = 1'b1;
                  next_flash = 1'b1;
               end
               else
                  next_hold_cnt = hold_cnt + 32'h1;
            end
         end
         VEC_MANUAL:
         begin
            next_flash = flash;
            next_flash_cnt = flash_cnt + 32'h1;
            if (flash_cnt == 32'(FLASH_CYCLES - 1))
            begin
               next_flash_cnt = '0;
               next_flash = ~flash;
            end
            if (!inp[VEC_IN_MENU] && !inp[VEC_IN_PLUS])
               next_wait_rel = 1'b0;
            if (cmd_chg)
               next_mode = VEC_AUTO;
            else if (combo && !combo_prev && !wait_rel)
               next_mode = VEC_AUTO;
            else if (menu_rise && !inp[VEC_IN_PLUS])
               next_man_suck = ~man_suck;
            if (next_mode == VEC_AUTO)
            begin
               next_man_suck = 1'b0;
               next_flash = 1'b0;
            end
         end
      endcase
   end

   // parameter intake and zero calibration, automatic mode only
   always_comb
   begin
      next_ctrl_en = ctrl_en;
      next_save_up = save_up;
      next_save_lo = save_lo;
      next_part_on = part_on;
      next_part_off = part_off;
      next_blow_time = blow_time;
      next_rejected = rejected;
      next_offset = offset;
      next_cal_err = cal_err;
      if (cfg_load)
      begin
         if (mode == VEC_AUTO && cfg_blow_time <= VEC_BLOW_MAX)
         begin
            next_ctrl_en = cfg_ctrl_enable;
            next_save_up = cfg_save_upper_limit;
            next_save_lo = cfg_save_lower_limit;
            next_part_on = cfg_part_on_limit;
            next_part_off = cfg_part_off_limit;
            next_blow_time = cfg_blow_time;
            next_rejected = 1'b0;
         end
         else
            next_rejected = 1'b1;
      end
      if (cal_request && mode == VEC_AUTO)
      begin
         // signed compare on both ends, so negative offsets are judged too
         if (vacuum_raw <= $signed(VEC_VAC_W'(VEC_CAL_LIM))
             && vacuum_raw >= -$signed(VEC_VAC_W'(VEC_CAL_LIM)))
         begin
            next_offset = vacuum_raw;
            next_cal_err = 1'b0;
         end
         else
            next_cal_err = 1'b1;
      end
   end

   // corrected vacuum, clamped at zero
   assign diff = {vacuum_raw[VEC_VAC_W-1], vacuum_raw} - {offset[VEC_VAC_W-1], offset};
   assign vac = diff[VEC_VAC_W] ? '0 : diff[VEC_VAC_W-1:0];

   // demand selection: manual buttons or external commands
   always_comb
   begin
      if (mode == VEC_MANUAL)
      begin
         suck_req = man_suck;
         blow_req = inp[VEC_IN_PLUS] & ~inp[VEC_IN_MENU];
      end
      else
      begin
         suck_req = inp[VEC_IN_SUC];
         blow_req = inp[VEC_IN_BLOW];
      end
   end
   assign suck_fall = suck_prev & ~suck_req;

   // timed blow-off only for a nonzero time
   vec_blow_timer #(
      .W(VEC_BLOW_W),
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tmr (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .start(suck_fall && blow_time != '0),
      .load(blow_time),
      .active(tmr_active)
   );

   // blow-off priority, air saving and part present
   always_comb
   begin
      blow = blow_req | tmr_active;
      suction_on = suck_req & ~blow;
      next_save_off = save_off;
      if (!suction_on || !ctrl_en)
         next_save_off = 1'b0;
      else if (vac >= VEC_VAC_W'(save_up))
         next_save_off = 1'b1;
      else if (vac < VEC_VAC_W'(save_lo))
         next_save_off = 1'b0;
      gen = suction_on & ~next_save_off;
      next_part = part;
      if (vac >= VEC_VAC_W'(part_on))
         next_part = 1'b1;
      else if (vac < VEC_VAC_W'(part_off))
         next_part = 1'b0;
   end

   // register all state and outputs
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         mode <= VEC_AUTO;
         hold_cnt <= '0;
         flash_cnt <= '0;
         wait_rel <= 1'b0;
         man_suck <= 1'b0;
         flash <= 1'b0;
         inp_prev <= '0;
         ctrl_en <= VEC_RST_CTRL;
         save_up <= VEC_RST_SAVE_UP;
         save_lo <= VEC_RST_SAVE_LO;
         part_on <= VEC_RST_PART_ON;
         part_off <= VEC_RST_PART_OFF;
         blow_time <= VEC_RST_BLOW;
         rejected <= 1'b0;
         offset <= '0;
         cal_err <= 1'b0;
         suck_prev <= 1'b0;
         save_off <= 1'b0;
         part <= 1'b0;
         nozzle_drive <= 1'b0;
         suction_valve <= 1'b0;
         blowoff_valve <= 1'b0;
         blowoff_indication <= 1'b0;
         part_present <= 1'b0;
         led_limit1 <= 1'b0;
         led_limit2 <= 1'b0;
         led_suction <= 1'b0;
         led_blowoff <= 1'b0;
         manual_mode <= 1'b0;
         cfg_rejected <= 1'b0;
         cal_error <= 1'b0;
      end
      else
      begin
         mode <= next_mode;
         hold_cnt <= next_hold_cnt;
         flash_cnt <= next_flash_cnt;
         wait_rel <= next_wait_rel;
         man_suck <= next_man_suck;
         flash <= next_flash;
         inp_prev <= inp;
         ctrl_en <= next_ctrl_en;
         save_up <= next_save_up;
         save_lo <= next_save_lo;
         part_on <= next_part_on;
         part_off <= next_part_off;
         blow_time <= next_blow_time;
         rejected <= next_rejected;
         offset <= next_offset;
         cal_err <= next_cal_err;
         suck_prev <= suck_req;
         save_off <= next_save_off;
         part <= next_part;
         nozzle_drive <= nc_variant ? gen : ~gen;
         suction_valve <= gen;
         blowoff_valve <= blow;
         blowoff_indication <= blow;
         part_present <= next_part;
         led_limit1 <= (next_mode == VEC_MANUAL) ? next_flash : next_save_off;
         led_limit2 <= (next_mode == VEC_MANUAL) ? next_flash : next_part;
         led_suction <= suction_on;
         led_blowoff <= blow;
         manual_mode <= (next_mode == VEC_MANUAL);
         cfg_rejected <= next_rejected;
         cal_error <= next_cal_err;
      end
   end

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   chk_nozzle_polarity: assert property (!$past(sys_rst) |-> nozzle_drive == (nc_variant ? suction_valve : !suction_valve))
      else $error("nozzle polarity wrong");
   chk_save_stop: assert property (suction_on && ctrl_en && vac >= VEC_VAC_W'(save_up) |=> !suction_valve)
      else $error("air saving did not stop generation");
   chk_save_resume: assert property (suction_on && ctrl_en && vac < VEC_VAC_W'(save_lo) |=> suction_valve)
      else $error("air saving did not resume generation");
   chk_part_follow: assert property (vac >= VEC_VAC_W'(part_on) |=> part_present)
      else $error("part present not set");
   chk_blow_shown: assert property (blowoff_indication == blowoff_valve)
      else $error("blow-off indication mismatch");
   chk_cfg_frozen: assert property (mode == VEC_MANUAL |=> $stable(blow_time) && $stable(save_up))
      else $error("parameter changed in manual mode");
   chk_manual_cmd_exit: assert property (mode == VEC_MANUAL && cmd_chg |=> mode == VEC_AUTO)
      else $error("command change did not leave manual mode");
   chk_no_ctrl_full: assert property (suction_on && !ctrl_en |=> suction_valve)
      else $error("continuous suction broken");
   chk_blow_prio: assert property (blow_req |=> blowoff_valve && !suction_valve)
      else $error("blow-off did not win over suction");
   chk_ext_blow_end: assert property (blow_time == '0 && !blow_req && !tmr_active |=> !blowoff_valve)
      else $error("external blow-off outlived its command");
   chk_timed_start: assert property (suck_fall && blow_time != '0 |=> ##1 blowoff_valve)
      else $error("timed blow-off did not start");
   chk_cal_reject: assert property (cal_request && mode == VEC_AUTO && vacuum_raw > $signed(VEC_VAC_W'(VEC_CAL_LIM)) |=> cal_error && $stable(offset))
      else $error("calibration out of range accepted");

   cov_enter_manual: cover property (mode == VEC_AUTO ##1 mode == VEC_MANUAL);
   cov_timed_blow: cover property (suck_fall && blow_time != '0 ##2 blowoff_valve);
   cov_save_cycle: cover property (suction_valve ##1 !suction_valve && suck_req ##[1:50] suction_valve);
   cov_cal_error: cover property (!cal_error ##1 cal_error);
endmodule : vec_ctrl
`default_nettype wire

// *** sim/vec_host_model.sv ***
/*
 system controller model: turns bench requests into command pin levels.
 assumes the bench changes its requests just after rising clock edges.
*/
`timescale 1ns/1ns
`default_nettype none
module vec_host_model (
   input wire logic clk_sys,
   input wire logic want_suction,
   input wire logic want_blowoff,
   output logic cmd_suction = 1'b0,
   output logic cmd_blowoff = 1'b0
);
   // command levels, launched on the clock like a plc output card
   always @(posedge clk_sys)
   begin
      cmd_suction <= want_suction;
      cmd_blowoff <= want_blowoff;
   end
endmodule : vec_host_model
`default_nettype wire

// *** sim/vacuum_ejector_controller_tb.sv ***
/*
 self-checking bench for the ejector control core with shortened counts.
 assumes the host model drives the command pins and the bench the rest.
*/
`timescale 1ns/1ns
`default_nettype none
module vacuum_ejector_controller_tb;
   import vec_pkg::*;
   localparam int DEB = 4;
   localparam int TICK = 5;
   localparam int HOLD = 20;
   localparam int FLASH = 3;
   localparam int PIN = 12;
   logic clk_sys = 1'b0;
   logic sys_rst, nc_variant, want_suc, want_blow, btn_menu, btn_plus;
   logic cmd_suction, cmd_blowoff, cfg_load, cfg_ctrl_enable, cal_request, flash_was;
   logic signed [VEC_VAC_W-1:0] vacuum_raw;
   logic [VEC_BLOW_W-1:0] cfg_blow_time;
   logic nozzle_drive, suction_valve, blowoff_valve, blowoff_indication, part_present;
   logic led_limit1, led_limit2, led_suction, led_blowoff, manual_mode, cfg_rejected, cal_error;
   int mismatches = 0;
   int n_checks = 0;
   int cycles = 0;
   logic signed [VEC_VAC_W-1:0] cal_raw [4] = '{12'sd31, 12'sd30, -12'sd31, 12'sd0};
   logic cal_bad [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

   // 100 MHz clock
   always #5 clk_sys = ~clk_sys;

   vec_host_model host (.clk_sys(clk_sys), .want_suction(want_suc), .want_blowoff(want_blow),
      .cmd_suction(cmd_suction), .cmd_blowoff(cmd_blowoff));

   vec_ctrl #(.DEB_CYCLES(DEB), .TICK_CYCLES(TICK), .HOLD_CYCLES(HOLD), .FLASH_CYCLES(FLASH))
   uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_suction(cmd_suction),
      .cmd_blowoff(cmd_blowoff), .btn_menu(btn_menu), .btn_plus(btn_plus),
      .vacuum_raw(vacuum_raw), .nc_variant(nc_variant), .cfg_load(cfg_load),
      .cfg_ctrl_enable(cfg_ctrl_enable), .cfg_save_upper_limit(VEC_RST_SAVE_UP),
      .cfg_save_lower_limit(VEC_RST_SAVE_LO), .cfg_part_on_limit(VEC_RST_PART_ON),
      .cfg_part_off_limit(VEC_RST_PART_OFF), .cfg_blow_time(cfg_blow_time),
      .cal_request(cal_request), .nozzle_drive(nozzle_drive), .suction_valve(suction_valve),
      .blowoff_valve(blowoff_valve), .blowoff_indication(blowoff_indication),
      .part_present(part_present), .led_limit1(led_limit1), .led_limit2(led_limit2),
      .led_suction(led_suction), .led_blowoff(led_blowoff), .manual_mode(manual_mode),
      .cfg_rejected(cfg_rejected), .cal_error(cal_error));

   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc

   task check(input string what, input logic seen, input logic exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %b seen %b", what, exp, seen);
      end
   endtask : check

   task stop_test;
      if (mismatches == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test

   // command requests, then time for sync and debounce
   task cmd(input logic s, input logic b);
      @(posedge clk_sys);
      want_suc <= s;
      want_blow <= b;
      cyc(PIN);
   endtask : cmd

   task btn(input logic m, input logic p, input int n);
      @(posedge clk_sys);
      btn_menu <= m;
      btn_plus <= p;
      cyc(n);
   endtask : btn

   task vac(input int v);
      @(posedge clk_sys);
      vacuum_raw <= VEC_VAC_W'(v);
      cyc(3);
   endtask : vac

   task cfg(input logic ctrl, input logic [VEC_BLOW_W-1:0] bt);
      @(posedge clk_sys);
      cfg_ctrl_enable <= ctrl;
      cfg_blow_time <= bt;
      cfg_load <= 1'b1;
      @(posedge clk_sys);
      cfg_load <= 1'b0;
      cyc(2);
   endtask : cfg

   // hang guard
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         mismatches++;
         stop_test();
      end
   end

   initial
   begin
      sys_rst = 1'b1;
      nc_variant = 1'b1;
      want_suc = 1'b0;
      want_blow = 1'b0;
      btn_menu = 1'b0;
      btn_plus = 1'b0;
      vacuum_raw = '0;
      cfg_load = 1'b0;
      cfg_ctrl_enable = 1'b1;
      cfg_blow_time = '0;
      cal_request = 1'b0;
      cyc(8);
      sys_rst <= 1'b0;
      cyc(3);
      check("nozzle nc idle", nozzle_drive, 1'b0);
      sys_rst <= 1'b1;
      nc_variant <= 1'b0;
      cyc(8);
      sys_rst <= 1'b0;
      cyc(3);
      check("nozzle no idle", nozzle_drive, 1'b1);
      check("mode after reset", manual_mode, 1'b0);
      // automatic suction with air saving and part detection
      cmd(1'b1, 1'b0);
      check("suction on", suction_valve, 1'b1);
      check("nozzle no suction", nozzle_drive, 1'b0);
      vac(600);
      check("save stop", suction_valve, 1'b0);
      check("save led", led_limit1, 1'b1);
      check("part on", part_present, 1'b1);
      check("part led", led_limit2, 1'b1);
      vac(550);
      check("save hold", suction_valve, 1'b0);
      vac(499);
      check("save restart", suction_valve, 1'b1);
      vac(360);
      check("part hold", part_present, 1'b1);
      vac(349);
      check("part off", part_present, 1'b0);
      cfg(1'b0, '0);
      check("cfg auto ok", cfg_rejected, 1'b0);
      vac(700);
      check("continuous", suction_valve, 1'b1);
      // external blow-off wins over suction
      cmd(1'b1, 1'b1);
      check("ext blow", blowoff_valve, 1'b1);
      check("blow shown", blowoff_indication, 1'b1);
      check("suction held off", suction_valve, 1'b0);
      cmd(1'b1, 1'b0);
      check("ext blow end", blowoff_valve, 1'b0);
      check("suction back", suction_valve, 1'b1);
      // timed blow-off of 3 ticks when suction ends
      cfg(1'b1, 10'h003);
      vac(0);
      @(posedge clk_sys);
      want_suc <= 1'b0;
      cyc(PIN);
      check("timed blow on", blowoff_valve, 1'b1);
      cyc(18);
      check("timed blow end", blowoff_valve, 1'b0);
      cmd(1'b1, 1'b1);
      check("timed blow cmd", blowoff_valve, 1'b1);
      check("timed suction off", suction_valve, 1'b0);
      cmd(1'b0, 1'b0);
      cyc(30);
      cfg(1'b1, 10'h3e8);
      check("time over 999", cfg_rejected, 1'b1);
      cfg(1'b1, VEC_BLOW_MAX);
      check("time 999", cfg_rejected, 1'b0);
      cfg(1'b1, '0);
      check("time zero", cfg_rejected, 1'b0);
      // zero calibration window edges
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk_sys);
         vacuum_raw <= cal_raw[i];
         cal_request <= 1'b1;
         @(posedge clk_sys);
         cal_request <= 1'b0;
         cyc(2);
         check("cal window", cal_error, cal_bad[i]);
      end
      // manual mode by long both-button hold
      btn(1'b1, 1'b1, HOLD + PIN + 5);
      check("manual entry", manual_mode, 1'b1);
      flash_was = led_limit1;
      cyc(FLASH);
      check("limit flash", led_limit1, ~flash_was);
      check("limit2 flash", led_limit2, ~flash_was);
      cfg(1'b1, '0);
      check("cfg in manual", cfg_rejected, 1'b1);
      btn(1'b0, 1'b0, PIN);
      btn(1'b1, 1'b0, PIN);
      check("manual suction", suction_valve, 1'b1);
      check("suction led", led_suction, 1'b1);
      vac(600);
      check("manual save", suction_valve, 1'b0);
      vac(0);
      btn(1'b0, 1'b0, PIN);
      btn(1'b0, 1'b1, PIN);
      check("manual blow", blowoff_valve, 1'b1);
      check("blow led", led_blowoff, 1'b1);
      check("blow over suction", suction_valve, 1'b0);
      btn(1'b0, 1'b0, PIN);
      check("manual blow end", blowoff_valve, 1'b0);
      check("blow led off", led_blowoff, 1'b0);
      btn(1'b1, 1'b0, PIN);
      btn(1'b0, 1'b0, PIN);
      check("suction toggled off", led_suction, 1'b0);
      btn(1'b1, 1'b1, PIN);
      check("short press exit", manual_mode, 1'b0);
      check("flash stopped", led_limit1, 1'b0);
      btn(1'b0, 1'b0, PIN);
      // command change leaves manual mode
      btn(1'b1, 1'b1, HOLD + PIN + 5);
      check("manual again", manual_mode, 1'b1);
      btn(1'b0, 1'b0, PIN);
      cmd(1'b1, 1'b0);
      check("cmd exit", manual_mode, 1'b0);
      cmd(1'b0, 1'b0);
      stop_test();
   end
endmodule : vacuum_ejector_controller_tb
`default_nettype wire
